// ---- rtl/mcpc_top.sv ----
// machine-cycle scheduler for video, processor, dma and i/o paths
`timescale 1ns/100ps
// Overview of operation
// RULE1 - processor gets memory only in the processor half of each machine cycle
// RULE2 - other half always belongs to video refresh fetches
// RULE3 - 24-bit logical address taken in video half, translated before processor half
// RULE4 - upper physical bits may settle after the processor half begins
// RULE5 - no other transfer while the processor uses the buffered data bus
// RULE6 - video and dma addresses go to memory untranslated
// RULE7 - boot rom reachable through translation and with translation bypassed
// RULE8 - video addresses enter the memory mux, read data returns to video
// RULE9 - processor i/o cycle may overlap a video memory access
// RULE10 - i/o segment suppresses memory access, address goes to i/o decode
// RULE11 - i/o decode enables the board holding the addressed peripheral
// RULE12 - dma high byte held in a latch, peripheral steps low bits
// RULE13 - i/o board reloads the high byte, may coincide with video access
// RULE14 - dma address is latched high byte plus board low lines
// RULE15 - dma address presented like a processor access, data on buffered bus
// RULE16 - no other transfer during a dma half cycle
// RULE17 - dma burst starts with processor releasing bus to the dma master
// RULE18 - dma master produces processor-like cycles within system timing
// RULE19 - each machine cycle is equal video then processor halves
// RULE20 - source select low passes video address, high passes translated or dma
// RULE21 - after a burst the bus returns to the processor before its next half
module mcpc_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cpu_as,
    input wire logic [mcpc_pkg::LA_W-1:0] cpu_laddr,
    input wire logic cpu_we,
    input wire logic [mcpc_pkg::DW-1:0] cpu_wdata,
    output logic cpu_ack,
    output logic cpu_done,
    output logic cpu_fault,
    output logic [mcpc_pkg::DW-1:0] cpu_rdata,
    input wire logic map_wr,
    input wire logic [mcpc_pkg::SEG_W-1:0] map_idx,
    input wire logic [mcpc_pkg::BASE_W-1:0] map_base,
    input wire logic [mcpc_pkg::PG_W-1:0] map_bound,
    input wire mcpc_pkg::mcpc_seg_t map_mode,
    input wire logic rom_bypass,
    input wire logic [mcpc_pkg::PA_W-1:0] video_addr,
    output logic video_fetch_ack,
    output logic video_valid,
    input wire logic video_ready,
    output logic [mcpc_pkg::DW-1:0] video_data,
    output logic [mcpc_pkg::PA_W-1:0] mem_addr,
    output logic memory_address_source_select,
    output logic mem_ras,
    output logic mem_cas,
    output logic mem_we,
    output logic mem_rom_sel,
    output logic [mcpc_pkg::DW-1:0] mem_wdata,
    input wire logic [mcpc_pkg::DW-1:0] mem_rdata,
    output logic xfer_lock,
    output logic [mcpc_pkg::PA_W-1:0] io_addr,
    output logic [mcpc_pkg::BOARD_N-1:0] io_board_en,
    output logic io_strobe,
    output logic io_we,
    output logic [mcpc_pkg::DW-1:0] io_wdata,
    input wire logic [mcpc_pkg::DW-1:0] io_rdata,
    input wire logic dma_hi_load,
    input wire logic [mcpc_pkg::DHI_W-1:0] dma_hi_data,
    input wire logic dma_bus_req,
    output logic dma_bus_grant,
    input wire logic dma_xfer,
    input wire logic [mcpc_pkg::DLO_W-1:0] dma_low,
    input wire logic dma_we,
    input wire logic [mcpc_pkg::DW-1:0] dma_wdata,
    output logic dma_done,
    output logic [mcpc_pkg::DW-1:0] dma_rdata
);
    import mcpc_pkg::*;
    typedef struct packed {
        mcpc_pins_t sa;
        mcpc_pins_t sb;
        mcpc_pins_t pv;
        logic ph;
        logic [CNT_W-1:0] cnt;
        mcpc_mem_t mst;
        mcpc_own_t own;
        logic sel;
        logic [PA_W-1:0] mem_addr;
        logic mem_we;
        logic rom_sel;
        logic [DW-1:0] mem_wd;
        logic as_hold;
        logic cpu_pend;
        logic [PA_W-1:0] cpu_pa;
        mcpc_seg_t cpu_mode;
        logic cpu_we;
        logic [DW-1:0] cpu_wd;
        logic cpu_ack;
        logic cpu_done;
        logic cpu_fault;
        logic [DW-1:0] cpu_rd;
        logic io_busy;
        logic [CNT_W-1:0] io_cnt;
        logic [BOARD_N-1:0] io_en;
        logic [PA_W-1:0] io_addr;
        logic io_we;
        logic [DW-1:0] io_wd;
        logic [DHI_W-1:0] dma_hi;
        logic grant;
        logic dma_pend;
        logic [PA_W-1:0] dma_pa;
        logic dma_we;
        logic [DW-1:0] dma_wd;
        logic dma_done;
        logic [DW-1:0] dma_rd;
        logic vid_ack;
        logic vid_push;
        logic [DW-1:0] vid_data;
    } mcpc_st_t;
    mcpc_st_t s, next_s;
    mcpc_pins_t pin_in, p;
    logic hi_rise, xfer_rise, mem_busy, vid_room;
    logic [PA_W-1:0] xl_pa;
    mcpc_seg_t xl_mode;

    mcpc_xlate u_xlate (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .map_wr(map_wr),
        .map_idx(map_idx),
        .map_base(map_base),
        .map_bound(map_bound),
        .map_mode(map_mode),
        .laddr(cpu_laddr),
        .bypass(rom_bypass),
        .paddr(xl_pa),
        .mode(xl_mode)
    );

    // a stalled display sink skips fetches instead of dropping words
    mcpc_fifo2 #(.W(DW), .D(2)) u_vbuf (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .in_valid(s.vid_push),
        .in_ready(vid_room),
        .in_data(s.vid_data),
        .out_valid(video_valid),
        .out_ready(video_ready),
        .out_data(video_data)
    );

    // off-board signals; only the second stage and later are looked at
    assign pin_in = '{dma_req: dma_bus_req, dma_xfer: dma_xfer, hi_load: dma_hi_load, dma_we: dma_we,
                      dma_low: dma_low, dma_wd: dma_wdata, hi_data: dma_hi_data, io_rd: io_rdata};
    assign p = s.sb;
    assign hi_rise = p.hi_load && !s.pv.hi_load;
    assign xfer_rise = p.dma_xfer && !s.pv.dma_xfer;
    assign mem_busy = s.mst != MS_IDLE;

    always_comb begin
        next_s = s;
        next_s.sa = pin_in;
        next_s.sb = s.sa;
        next_s.pv = s.sb;
        next_s.cpu_ack = 1'h0;
        next_s.cpu_done = 1'h0;
        next_s.cpu_fault = 1'h0;
        next_s.dma_done = 1'h0;
        next_s.vid_ack = 1'h0;
        next_s.vid_push = 1'h0;
        // fixed half-cycle sequencer, video half first
        if (s.cnt == CNT_LAST) begin
            next_s.cnt = '0;
            next_s.ph = !s.ph; // see RULE19
        end else begin
            next_s.cnt = s.cnt + CNT_W'(1);
        end
        // high byte latch needs no memory bus, so it loads at any time
        if (hi_rise) begin
            next_s.dma_hi = p.hi_data; // see RULE12, RULE13
        end
        // processor hands the bus over only when it has nothing in flight
        if (!p.dma_req) begin
            next_s.grant = 1'h0; // see RULE21
        end else if (!s.cpu_pend && !s.io_busy && !(s.own == OWN_CPU && mem_busy)) begin
            next_s.grant = 1'h1; // see RULE17
        end
        if (!s.grant) begin
            next_s.dma_pend = 1'h0;
        end
        // each dma strobe forms one physical address from latch and low lines
        if (xfer_rise && s.grant && !s.dma_pend) begin
            next_s.dma_pend = 1'h1;
            next_s.dma_pa = {s.dma_hi, p.dma_low, 1'h0}; // see RULE14, RULE6
            next_s.dma_we = p.dma_we;
            next_s.dma_wd = p.dma_wd;
        end
        // address strobe is taken during the video half only
        if (!cpu_as) begin
            next_s.as_hold = 1'h0;
        end
        if (!s.ph && cpu_as && !s.as_hold && !s.cpu_pend && !s.io_busy && !s.grant && !p.dma_req) begin
            next_s.as_hold = 1'h1;
            next_s.cpu_ack = 1'h1; // see RULE3
            if (xl_mode == SEG_BAD) begin
                next_s.cpu_fault = 1'h1;
            end else begin
                next_s.cpu_pend = 1'h1;
                next_s.cpu_pa = xl_pa;
                next_s.cpu_mode = xl_mode;
                next_s.cpu_we = cpu_we;
                next_s.cpu_wd = cpu_wdata;
                if (xl_mode == SEG_IO) begin
                    // i/o space: no memory cycle, address goes to the decode
                    next_s.io_busy = 1'h1; // see RULE10, RULE9
                    next_s.io_cnt = '0;
                    next_s.io_addr = xl_pa;
                    next_s.io_en = BOARD_N'(1) << xl_pa[IOB_LSB +: IOB_W]; // see RULE11
                    next_s.io_we = cpu_we;
                    next_s.io_wd = cpu_wdata;
                end
            end
        end
        // system bus cycle runs on its own count, independent of the halves
        if (s.io_busy) begin
            if (s.io_cnt == IO_LAST) begin
                next_s.io_busy = 1'h0;
                next_s.io_en = '0;
                next_s.cpu_pend = 1'h0;
                next_s.cpu_done = 1'h1;
                next_s.cpu_rd = p.io_rd;
            end else begin
                next_s.io_cnt = s.io_cnt + CNT_W'(1);
            end
        end
        // owner of the coming half is chosen on the last count of this one
        if (s.cnt == CNT_LAST) begin
            next_s.mst = MS_IDLE;
            next_s.own = OWN_NONE;
            next_s.sel = !s.ph; // see RULE20
            next_s.mem_we = 1'h0;
            next_s.rom_sel = 1'h0;
            if (!s.ph) begin
                if (s.grant && s.dma_pend) begin
                    next_s.own = OWN_DMA; // see RULE15, RULE16
                    next_s.mst = MS_RAS;
                    next_s.mem_addr = s.dma_pa;
                    next_s.mem_we = s.dma_we;
                    next_s.mem_wd = s.dma_wd;
                end else if (next_s.cpu_pend && next_s.cpu_mode != SEG_IO && !s.grant) begin
                    next_s.own = OWN_CPU; // see RULE1
                    next_s.mst = MS_RAS;
                    // row bits first, upper bits follow inside the half
                    next_s.mem_addr = {s.mem_addr[PA_W-1:PG_LSB], next_s.cpu_pa[PG_LSB-1:0]};
                    next_s.mem_we = next_s.cpu_we;
                    next_s.mem_wd = next_s.cpu_wd;
                    next_s.rom_sel = next_s.cpu_mode == SEG_ROM; // see RULE7
                end
            end else if (vid_room) begin
                next_s.own = OWN_VID; // see RULE2
                next_s.mst = MS_RAS;
                next_s.mem_addr = video_addr; // see RULE8, RULE6
                next_s.vid_ack = 1'h1;
            end
        end else begin
            if (s.cnt == CNT_UPPER && s.own == OWN_CPU) begin
                next_s.mem_addr[PA_W-1:PG_LSB] = s.cpu_pa[PA_W-1:PG_LSB]; // see RULE4
            end
            if (s.cnt == CNT_CAS && s.mst == MS_RAS) begin
                next_s.mst = MS_CAS;
            end
            if (s.cnt == CNT_CAP && s.mst == MS_CAS) begin
                next_s.mst = MS_END;
                case (s.own)
                    OWN_VID: begin
                        next_s.vid_push = 1'h1; // see RULE8
                        next_s.vid_data = mem_rdata;
                    end
                    OWN_CPU: begin
                        next_s.cpu_pend = 1'h0;
                        next_s.cpu_done = 1'h1;
                        next_s.cpu_rd = mem_rdata;
                    end
                    OWN_DMA: begin
                        next_s.dma_pend = 1'h0;
                        next_s.dma_done = 1'h1;
                        next_s.dma_rd = mem_rdata;
                    end
                    default: begin
                        next_s.mst = MS_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.dma_hi <= RST_DMA_HI;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign cpu_ack = s.cpu_ack;
    assign cpu_done = s.cpu_done;
    assign cpu_fault = s.cpu_fault;
    assign cpu_rdata = s.cpu_rd;
    assign video_fetch_ack = s.vid_ack;
    assign mem_addr = s.mem_addr;
    assign memory_address_source_select = s.sel;
    assign mem_ras = s.mst == MS_RAS || s.mst == MS_CAS;
    assign mem_cas = s.mst == MS_CAS;
    assign mem_we = s.mem_we;
    assign mem_rom_sel = s.rom_sel;
    assign mem_wdata = s.mem_wd;
    assign xfer_lock = (s.own == OWN_CPU || s.own == OWN_DMA) && mem_busy; // see RULE5, RULE16
    assign io_addr = s.io_addr;
    assign io_board_en = s.io_en;
    assign io_strobe = s.io_busy;
    assign io_we = s.io_we;
    assign io_wdata = s.io_wd;
    assign dma_bus_grant = s.grant;
    assign dma_done = s.dma_done;
    assign dma_rdata = s.dma_rd;

    a_cpu_half_only: assert property (@(posedge clk) disable iff (!resetn) // see RULE1
        s.own == OWN_CPU && mem_busy |-> s.ph)
        else $error("processor memory cycle outside processor half");
    a_video_half_own: assert property (@(posedge clk) disable iff (!resetn) // see RULE2
        !s.ph && mem_busy |-> s.own == OWN_VID)
        else $error("video half used by another master");
    a_accept_in_video: assert property (@(posedge clk) disable iff (!resetn) // see RULE3
        s.cpu_ack |-> !$past(s.ph))
        else $error("address taken outside video half");
    a_upper_bits_late: assert property (@(posedge clk) disable iff (!resetn) // see RULE4
        s.own == OWN_CPU && s.mst == MS_CAS |-> s.mem_addr == s.cpu_pa)
        else $error("column strobe before full physical address");
    a_lock_alone: assert property (@(posedge clk) disable iff (!resetn) // see RULE5
        xfer_lock |-> !s.io_busy && !(s.own == OWN_CPU && s.grant))
        else $error("second transfer during locked half");
    a_dma_address: assert property (@(posedge clk) disable iff (!resetn) // see RULE14
        s.own == OWN_DMA && s.mst == MS_RAS |-> s.mem_addr == s.dma_pa && s.sel && s.grant)
        else $error("dma address not presented as formed");
    a_video_select: assert property (@(posedge clk) disable iff (!resetn) // see RULE20
        s.own == OWN_VID && mem_busy |-> !memory_address_source_select)
        else $error("source select high during video fetch");
    a_io_no_memory: assert property (@(posedge clk) disable iff (!resetn) // see RULE10
        s.io_busy |-> !(s.own == OWN_CPU && mem_busy))
        else $error("memory cycle run for an i/o segment");
    a_board_enable: assert property (@(posedge clk) disable iff (!resetn) // see RULE11
        io_strobe |-> $onehot(io_board_en))
        else $error("i/o cycle without exactly one board enable");
    a_high_byte_load: assert property (@(posedge clk) disable iff (!resetn) // see RULE13
        ce && hi_rise |=> s.dma_hi == $past(p.hi_data))
        else $error("dma high byte not loaded");
    a_grant_release: assert property (@(posedge clk) disable iff (!resetn) // see RULE21
        ce && !p.dma_req |=> !dma_bus_grant)
        else $error("bus still granted after request dropped");
    a_half_length: assert property (@(posedge clk) disable iff (!resetn) // see RULE19
        ce && s.cnt == CNT_LAST |=> s.cnt == '0 && s.ph != $past(s.ph))
        else $error("half cycle did not end on its last count");
endmodule

// ---- rtl/mcpc_pkg.sv ----
// shared constants, types and encodings of the memory cycle path control
package mcpc_pkg;
    // clock and machine-cycle timing
    localparam int CLK_NS = 4;
    localparam int HALF_NS = 400;
    localparam int HALF_CYC = HALF_NS / CLK_NS;
    localparam int UPPER_NS = 60;
    localparam int UPPER_CYC = (UPPER_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAS_NS = 100;
    localparam int CAS_CYC = (CAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int IO_NS = 400;
    localparam int IO_CYC = (IO_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_UPPER = CNT_W'(UPPER_CYC);
    localparam logic [CNT_W-1:0] CNT_CAS = CNT_W'(CAS_CYC);
    localparam logic [CNT_W-1:0] CNT_CAP = CNT_W'(HALF_CYC - 3);
    localparam logic [CNT_W-1:0] IO_LAST = CNT_W'(IO_CYC - 1);
    // address and data layout
    localparam int LA_W = 24;
    localparam int PA_W = 21;
    localparam int DW = 16;
    localparam int SEG_W = 4;
    localparam int SEG_N = 16;
    localparam int SEG_LSB = 20;
    localparam int PG_LSB = 9;
    localparam int PG_W = 11;
    localparam int BASE_W = 12;
    localparam int IOB_LSB = 19;
    localparam int IOB_W = 2;
    localparam int BOARD_N = 4;
    localparam int DLO_W = 12;
    localparam int DHI_W = 8;
    localparam logic [DHI_W-1:0] RST_DMA_HI = 8'h00;
    // segment kinds held in the segment bound register
    typedef enum logic [1:0] {SEG_MEM = 2'h0, SEG_IO = 2'h1, SEG_ROM = 2'h2, SEG_BAD = 2'h3} mcpc_seg_t;
    // memory strobe sequence, gray along the path
    typedef enum logic [1:0] {MS_IDLE = 2'h0, MS_RAS = 2'h1, MS_CAS = 2'h3, MS_END = 2'h2} mcpc_mem_t;
    // owner of the current half cycle
    typedef enum logic [1:0] {OWN_NONE = 2'h0, OWN_VID = 2'h1, OWN_CPU = 2'h2, OWN_DMA = 2'h3} mcpc_own_t;
    // off-board inputs, carried through the synchroniser as one word
    typedef struct packed {
        logic dma_req;
        logic dma_xfer;
        logic hi_load;
        logic dma_we;
        logic [DLO_W-1:0] dma_low;
        logic [DW-1:0] dma_wd;
        logic [DHI_W-1:0] hi_data;
        logic [DW-1:0] io_rd;
    } mcpc_pins_t;
endpackage

// ---- rtl/mcpc_fifo2.sv ----
// small valid/ready buffer for display data
`timescale 1ns/100ps
module mcpc_fifo2 #(
    parameter int W = 16,
    parameter int D = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import mcpc_pkg::*;
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } mcpc_fst_t;
    mcpc_fst_t s, next_s;
    logic push, pop;

    // full and empty come straight from the count
    assign in_ready = s.cnt != CW'(D);
    assign out_valid = s.cnt != '0;
    assign out_data = s.mem[s.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointers wrap at depth, not at a power of two
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + AW'(1);
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + AW'(1);
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    a_no_overrun: assert property (@(posedge clk) disable iff (!resetn) in_valid |-> in_ready) // see RULE8
        else $error("display word pushed into a full buffer");
endmodule

// ---- rtl/mcpc_xlate.sv ----
// logical to physical translation with segment bound table
`timescale 1ns/100ps
module mcpc_xlate (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic map_wr,
    input wire logic [mcpc_pkg::SEG_W-1:0] map_idx,
    input wire logic [mcpc_pkg::BASE_W-1:0] map_base,
    input wire logic [mcpc_pkg::PG_W-1:0] map_bound,
    input wire mcpc_pkg::mcpc_seg_t map_mode,
    input wire logic [mcpc_pkg::LA_W-1:0] laddr,
    input wire logic bypass,
    output logic [mcpc_pkg::PA_W-1:0] paddr,
    output mcpc_pkg::mcpc_seg_t mode
);
    import mcpc_pkg::*;
    typedef struct packed {
        logic [BASE_W-1:0] base;
        logic [PG_W-1:0] bound;
        mcpc_seg_t kind;
    } mcpc_ent_t;
    typedef struct packed {
        mcpc_ent_t [SEG_N-1:0] tbl;
    } mcpc_xst_t;
    localparam mcpc_ent_t ENT_RST = '{base: '0, bound: '0, kind: SEG_BAD};
    mcpc_xst_t s, next_s;
    mcpc_ent_t ent;
    logic [PG_W-1:0] pg;
    logic [BASE_W-1:0] hi;

    // segment bound table, unmapped segments fault until written
    always_comb begin
        next_s = s;
        if (map_wr) begin
            next_s.tbl[map_idx] = '{base: map_base, bound: map_bound, kind: map_mode};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{tbl: {SEG_N{ENT_RST}}};
        end else if (ce) begin
            s <= next_s;
        end
    end

    // lookup is purely combinational so it settles inside the video half
    always_comb begin
        ent = s.tbl[laddr[SEG_LSB +: SEG_W]];
        pg = laddr[PG_LSB +: PG_W];
        hi = ent.base + {1'h0, pg};
        paddr = {hi, laddr[PG_LSB-1:0]}; // see RULE3
        mode = ent.kind; // see RULE10
        if (bypass) begin
            paddr = laddr[PA_W-1:0]; // see RULE7
            mode = SEG_ROM;
        end else if (pg > ent.bound) begin
            mode = SEG_BAD;
        end
    end

    a_rom_bypass: assert property (@(posedge clk) disable iff (!resetn) // see RULE7
        bypass |-> mode == SEG_ROM && paddr == laddr[PA_W-1:0])
        else $error("bypassed access did not reach boot rom untranslated");
endmodule

// ---- dv/mcpc_mem_model.sv ----
// behavioural main memory answering strobed cycles
`timescale 1ns/100ps
module mcpc_mem_model (
    input wire logic clk,
    input wire logic [mcpc_pkg::PA_W-1:0] mem_addr,
    input wire logic mem_cas,
    input wire logic mem_we,
    input wire logic [mcpc_pkg::DW-1:0] mem_wdata,
    output logic [mcpc_pkg::DW-1:0] mem_rdata
);
    import mcpc_pkg::*;
    logic [DW-1:0] m [0:255];
    logic [DW-1:0] last = 16'h0000;
    // low byte decode only: the bench keeps its addresses apart
    always @(posedge clk) if (mem_cas && mem_we) m[mem_addr[7:0]] <= mem_wdata;
    // released bus shows the inverse so stale data never matches
    always @(posedge clk) if (mem_cas) last <= m[mem_addr[7:0]];
    assign mem_rdata = mem_cas ? m[mem_addr[7:0]] : ~last;
endmodule

// ---- dv/memory_cycle_path_control_tb.sv ----
// self-checking bench for the machine-cycle scheduler
`timescale 1ns/100ps
module memory_cycle_path_control_tb;
    import mcpc_pkg::*;
    logic clk, resetn, ce, cpu_as, cpu_we, cpu_ack, cpu_done, cpu_fault, map_wr, rom_bypass, video_fetch_ack;
    logic video_valid, video_ready, memory_address_source_select, mem_ras, mem_cas, mem_we, mem_rom_sel;
    logic xfer_lock, io_strobe, io_we, dma_hi_load, dma_bus_req, dma_bus_grant, dma_xfer, dma_we, dma_done, f, cp, rs;
    logic [23:0] cpu_laddr, la;
    logic [15:0] cpu_wdata, cpu_rdata, video_data, mem_wdata, mem_rdata, io_wdata, io_rdata, dma_wdata, dma_rdata, d, r;
    logic [11:0] map_base, dma_low;
    logic [10:0] map_bound;
    logic [3:0] map_idx, io_board_en, be;
    logic [20:0] video_addr, mem_addr, io_addr, pa;
    logic [7:0] dma_hi_data;
    logic [31:0] seed = 32'd6366, x;
    mcpc_seg_t map_mode;
    int mismatches = 0, compares = 0, i;
    mcpc_top dut (.*);
    mcpc_mem_model mem (.clk, .mem_addr, .mem_cas, .mem_we, .mem_wdata, .mem_rdata);
    always #2 clk = ~clk;
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected translation: segment base plus page, offset kept
    function logic [20:0] xl(logic [11:0] b, logic [23:0] a);
        return {b + {1'b0, a[19:9]}, a[8:0]};
    endfunction
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test();
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wsig(ref logic s, input logic v);
        int n = 0;
        while (s !== v && n < 900) begin
            @(negedge clk);
            n++;
        end
        if (n >= 900) chk(0, 1);
    endtask
    task map(input logic [3:0] ix, input logic [11:0] b, input mcpc_seg_t md);
        @(negedge clk);
        {map_idx, map_base, map_bound, map_wr} = {ix, b, 11'h7ff, 1'b1};
        map_mode = md;
        @(negedge clk);
        map_wr = 0;
    endtask
    // one processor cycle; notes the address and any processor-half strobe
    task cpu(input logic [23:0] a, input logic we, input logic [15:0] wd);
        int n;
        @(negedge clk);
        {cpu_laddr, cpu_we, cpu_wdata, cpu_as, f, cp, n} = {a, we, wd, 1'b1, 1'b0, 1'b0, 32'd0};
        while (cpu_done !== 1'b1 && !f && n < 900) begin
            @(negedge clk);
            n++;
            f = cpu_fault === 1'b1;
            if (mem_cas === 1'b1 && memory_address_source_select === 1'b1)
                {cp, pa, rs} = {1'b1, mem_addr, mem_rom_sel};
            if (io_strobe === 1'b1) be = io_board_en;
        end
        r = cpu_rdata;
        cpu_as = 0;
        if (n >= 900) chk(0, 1);
    endtask
    // processor or dma data move only ever inside the processor half
    always @(negedge clk) if (resetn && xfer_lock === 1'b1) chk(memory_address_source_select, 1);
    // a refresh fetch always opens a video half with the video address selected
    always @(negedge clk) if (resetn && video_fetch_ack === 1'b1) chk(memory_address_source_select, 0);
    initial begin #160000; mismatches++; finish_test(); end
    initial begin
        {clk, resetn, ce, cpu_as, cpu_we, map_wr, rom_bypass, video_ready, dma_hi_load, dma_bus_req} = 10'h084;
        {dma_xfer, dma_we, cpu_laddr, cpu_wdata, map_idx, map_base, map_bound} = '0;
        map_mode = SEG_MEM;
        {video_addr, dma_low, dma_hi_data, dma_wdata, io_rdata} = {41'h0, xs()};
        repeat (5) @(negedge clk);
        resetn = 1;
        map(0, 0, SEG_MEM);
        cpu(24'h500000, 0, 0);
        chk(f, 1);
        for (i = 0; i < 4; i++) begin
            x = xs();
            map(2, x[31:20], SEG_MEM);
            la = {4'h2, x[11:0], 8'(i)};
            d = x[27:12];
            cpu(la, 1, d);
            chk(pa, xl(x[31:20], la));
            cpu(la, 0, 0);
            chk(r, d);
        end
        // i/o segment: no memory strobe, board chosen by top address bits
        x = xs();
        map(1, x[11:0], SEG_IO);
        la = {4'h1, x[31:12]};
        cpu(la, 0, 0);
        chk({cp, io_addr, r}, {1'b0, xl(x[11:0], la), io_rdata});
        chk(be, 4'h1 << (xl(x[11:0], la) >> 19));
        la = {4'h0, x[19:12], 4'h0, 8'h10};
        d = x[15:0];
        cpu(la, 1, d);
        rom_bypass = 1;
        cpu(la, 0, 0);
        rom_bypass = 0;
        chk(r, d);
        chk(rs, 1);
        // refresh fetch: stall receiver until full, then drain
        {video_addr, video_ready} = {la[20:0], 1'b0};
        repeat (400) @(negedge clk);
        video_ready = 1;
        repeat (800) @(negedge clk);
        wsig(video_valid, 1);
        chk(video_data, d);
        // dma burst from the latched high byte and board low lines
        x = xs();
        la = {4'h0, x[6:0], x[16:12], 7'h30, 1'b0};
        cpu(la, 1, x[31:16]);
        {dma_hi_data, dma_hi_load} = {1'b0, x[6:0], 1'b1};
        repeat (8) @(negedge clk);
        {dma_hi_load, dma_low, dma_bus_req} = {1'b0, x[16:12], 7'h30, 1'b1};
        wsig(dma_bus_grant, 1);
        repeat (5) @(negedge clk);
        dma_xfer = 1;
        wsig(dma_done, 1);
        chk(dma_rdata, x[31:16]);
        {dma_xfer, dma_bus_req} = 2'h0;
        wsig(dma_bus_grant, 0);
        cpu(la, 0, 0);
        chk(r, x[31:16]);
        finish_test();
    end
endmodule
